// [rtl/cfg_header.v]
/*
 * Configuration header registers of a two-socket bus bridge: both error
 * status registers, identification fields, master latency timer, socket
 * register base address and the bus numbers that steer Type 1 cycles.
 * Assumes a configuration cycle engine on core_clk presents one byte-lane
 * qualified dword access per cycle, and that event inputs are single-cycle
 * pulses from logic on the same clock.
 */
// Overview of operation
// R1: Primary status bit 15 sets on parity error; write 1 clears it.
// R2: Bit 14 in both status registers sets on system error; clears by 1.
// R3: Primary status bit 13 sets on received master abort; write 1 clears.
// R4: Primary status bit 12 sets on received target abort; write 1 clears.
// R5: Bit 11 in both status registers sets on signalled target abort.
// R6: Bits 10 to 9 of both status registers read fixed 01b.
// R7: Primary status bit 8 sets on data parity error; write 1 clears.
// R8: Bit 7 and bits 6 to 0 of both status registers read zero.
// R9: Card status sets bits 15, 13 and 8 on matching card events.
// R10: Card status bit 12 sets on card-side received target abort.
// R11: Latency setting 0 disables; 1 to 8 give 8 to 64 clocks.
// R12: Master ends transfer when grant removed and latency time expired.
// R13: Header type reads fixed 82h.
// R14: Class code reads base 06h, sub-class 07h, interface 00h.
// R15: Socket base stores bits 31 to 12; bits 11 to 0 read zero.
// R16: Socket base bits 3, 2 to 1 and 0 read zero.
// R17: Revision register is eight read-only bits.
// R18: Primary bus number is read/write, resets to zero.
// R19: Type 1 cycle to secondary bus is claimed as Type 0 on card side.
// R20: Subordinate and secondary numbers together select forwarded cycles.
// R21: Software programs secondary and subordinate numbers before forwarding.
// R22: A set event wins over a simultaneous write-1 clear.
// R23: Bus above secondary and up to subordinate forwards as Type 1.
`timescale 1ns/1ps
`include "cfg_header_defines.vh"

module cfg_header #(
    parameter [7:0] REVISION_VALUE = 8'h5a  // Arbitrary neutral revision code.
) (
    input  wire        core_clk,            // 125 MHz clock.
    input  wire        rst_b,               // Asynchronous reset, active low.
    input  wire        cfg_sel,             // Configuration access to this header.
    input  wire        cfg_wr,              // 1 write, 0 read.
    input  wire [7:0]  cfg_addr,            // Byte address; low two bits ignored.
    input  wire [3:0]  cfg_byte_en,         // Byte lane enables for writes.
    input  wire [31:0] cfg_wdata,           // Write data.
    output reg  [31:0] cfg_rdata,           // Read data, registered.
    output reg         cfg_rvalid,          // Read data valid pulse.
    input  wire        pci_parity_err,      // Primary parity error pulse.
    input  wire        pci_system_err,      // Primary system error signalled.
    input  wire        pci_master_abort,    // Primary master abort received.
    input  wire        pci_target_abort_rx, // Primary target abort received.
    input  wire        pci_target_abort_tx, // Primary target abort signalled.
    input  wire        pci_data_parity,     // Primary data parity error.
    input  wire        card_parity_err,     // Card side parity error.
    input  wire        card_system_err,     // Card side system error.
    input  wire        card_master_abort,   // Card side master abort received.
    input  wire        card_target_abort_rx, // Card side target abort received.
    input  wire        card_target_abort_tx, // Card side target abort signalled.
    input  wire        card_data_parity,    // Card side data parity error.
    input  wire        master_burst_start,  // Pulse when our master transaction starts.
    input  wire        master_active,       // Level while our master owns the bus.
    input  wire        grant_b,             // Bus grant as seen on the pin, active low.
    output reg         master_end_transfer, // Ask master to end transfer, registered.
    input  wire        type1_valid,         // Type 1 cycle seen on primary bus.
    input  wire [7:0]  type1_bus,           // Bus number field of that cycle.
    output reg         type1_claim,         // Claim the cycle, registered pulse.
    output reg         type1_to_type0,      // Convert to Type 0 on card side.
    output reg         type1_forward        // Forward unchanged as Type 1.
);

    ////////////////////////////////////////////////////////////////////////////
    // Register storage.
    reg [15:0] pci_status_reg;
    reg [15:0] card_status_reg;
    reg [7:0]  latency_reg;
    reg [19:0] socket_base_reg;
    reg [7:0]  primary_bus_reg;
    reg [7:0]  secondary_bus_reg;
    reg [7:0]  subordinate_bus_reg;
    reg [1:0]  grant_sync_reg;
    reg [6:0]  lat_count_reg;
    reg        lat_expired_reg;

    wire [7:0] dword   = {2'b00, cfg_addr[7:2]};
    wire       wr_hit  = cfg_sel & cfg_wr;

    // Sticky flag masks: the sticky bits are the only writable status bits.
    wire [15:0] sticky_mask = 16'hf900;
    wire [15:0] pci_sets = {pci_parity_err, pci_system_err, pci_master_abort,
                            pci_target_abort_rx, pci_target_abort_tx, 2'h0,
                            pci_data_parity, 8'h00};
    wire [15:0] card_sets = {card_parity_err, card_system_err, card_master_abort,
                             card_target_abort_rx, card_target_abort_tx, 2'h0,
                             card_data_parity, 8'h00};

    // Status halfwords sit in the upper lanes of their dwords.
    wire pci_sts_wr  = wr_hit && (dword == `OFS_PCI_ERROR_STATUS >> 2);
    wire card_sts_wr = wr_hit && (dword == `OFS_CARD_SIDE_STATUS >> 2);
    wire [15:0] sts_w1c_lanes = {{8{cfg_byte_en[3]}}, {8{cfg_byte_en[2]}}};
    wire [15:0] pci_clear  = pci_sts_wr ? (cfg_wdata[31:16] & sts_w1c_lanes) : 16'h0000;
    wire [15:0] card_clear = card_sts_wr ? (cfg_wdata[31:16] & sts_w1c_lanes) : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status flags; a set in the same cycle overrides the clear.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pci_status_reg  <= `STS_RESET;
            card_status_reg <= `STS_RESET;
        end else begin
            // see R1 R2 R3 R4 R5 R7 R22
            pci_status_reg  <= ((pci_status_reg & ~pci_clear) | pci_sets) & sticky_mask;
            // see R2 R5 R9 R10 R22
            card_status_reg <= ((card_status_reg & ~card_clear) | card_sets) & sticky_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Writable configuration fields, each under its own byte lane.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latency_reg         <= `LATENCY_RESET;
            socket_base_reg     <= `SOCKET_BASE_RESET;
            primary_bus_reg     <= `BUS_NUMBER_RESET;
            secondary_bus_reg   <= `BUS_NUMBER_RESET;
            subordinate_bus_reg <= `BUS_NUMBER_RESET;
        end else if (wr_hit) begin
            if (dword == `OFS_PRIMARY_LATENCY_TIMER >> 2) begin
                if (cfg_byte_en[1]) begin
                    latency_reg <= cfg_wdata[15:8];
                end
            end else if (dword == `OFS_SOCKET_REGS_BASE >> 2) begin
                // Bits 11 to 0 have no storage and read zero.  see R15
                if (cfg_byte_en[1]) begin
                    socket_base_reg[3:0] <= cfg_wdata[15:12];
                end
                if (cfg_byte_en[2]) begin
                    socket_base_reg[11:4] <= cfg_wdata[23:16];
                end
                if (cfg_byte_en[3]) begin
                    socket_base_reg[19:12] <= cfg_wdata[31:24];
                end
            end else if (dword == `OFS_PRIMARY_BUS_NUMBER >> 2) begin
                if (cfg_byte_en[0]) begin
                    primary_bus_reg <= cfg_wdata[7:0]; // see R18
                end
                if (cfg_byte_en[1]) begin
                    secondary_bus_reg <= cfg_wdata[15:8];
                end
                if (cfg_byte_en[2]) begin
                    subordinate_bus_reg <= cfg_wdata[23:16];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux with fixed fields; unmapped dwords read zero.
    reg [31:0] rdata_next;
    always @* begin
        rdata_next = 32'h00000000;
        if (dword == `OFS_PCI_ERROR_STATUS >> 2) begin
            // Fixed decode speed, zero in bit 7 and below.  see R6 R8
            rdata_next = {pci_status_reg[15:11], `STS_DEVSEL_MEDIUM, pci_status_reg[8],
                          8'h00, 16'h0000};
        end else if (dword == `OFS_REVISION_LEVEL >> 2) begin
            // see R14 R17
            rdata_next = {`CLASS_BASE_VALUE, `CLASS_SUB_VALUE, `CLASS_PROG_VALUE,
                          REVISION_VALUE};
        end else if (dword == `OFS_PRIMARY_LATENCY_TIMER >> 2) begin
            rdata_next = {8'h00, `HEADER_TYPE_VALUE, latency_reg, 8'h00}; // see R13
        end else if (dword == `OFS_SOCKET_REGS_BASE >> 2) begin
            rdata_next = {socket_base_reg, 12'h000}; // see R15 R16
        end else if (dword == `OFS_CARD_SIDE_STATUS >> 2) begin
            // see R6 R8
            rdata_next = {card_status_reg[15:11], `STS_DEVSEL_MEDIUM, card_status_reg[8],
                          8'h00, 16'h0000};
        end else if (dword == `OFS_PRIMARY_BUS_NUMBER >> 2) begin
            rdata_next = {8'h00, subordinate_bus_reg, secondary_bus_reg, primary_bus_reg};
        end
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata  <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_sel & ~cfg_wr;
            if (cfg_sel && !cfg_wr) begin
                cfg_rdata <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latency timer. Reserved settings above 8 are treated as disabled, so a
    // stray write cannot cut transfers short or stretch the count.
    wire       lat_enabled = (latency_reg != 8'h00) && (latency_reg <= `LAT_MAX_SETTING);
    wire [6:0] lat_limit   = {3'b000, latency_reg[3:0]} * `LAT_STEP_CLOCKS; // see R11

    // Grant arrives from a pin, so it is synchronised before use.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            grant_sync_reg <= 2'h3;
        end else begin
            grant_sync_reg <= {grant_sync_reg[0], grant_b};
        end
    end
    wire grant_lost = grant_sync_reg[1];

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lat_count_reg       <= 7'h00;
            lat_expired_reg     <= 1'b0;
            master_end_transfer <= 1'b0;
        end else begin
            if (master_burst_start) begin
                lat_count_reg   <= 7'h00;
                lat_expired_reg <= 1'b0;
            end else if (master_active && lat_enabled && !lat_expired_reg) begin
                lat_count_reg <= lat_count_reg + 7'h01;
                if (lat_count_reg + 7'h01 >= lat_limit) begin
                    lat_expired_reg <= 1'b1; // see R11
                end
            end
            // see R12
            master_end_transfer <= master_active && lat_enabled && lat_expired_reg &&
                                   grant_lost && !master_burst_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Type 1 steering against the bus number window set up by software.
    // see R21
    wire to_secondary = (type1_bus == secondary_bus_reg);
    wire below_window = (type1_bus > secondary_bus_reg) &&
                        (type1_bus <= subordinate_bus_reg);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            type1_claim    <= 1'b0;
            type1_to_type0 <= 1'b0;
            type1_forward  <= 1'b0;
        end else begin
            type1_to_type0 <= type1_valid && to_secondary;           // see R19
            type1_forward  <= type1_valid && below_window;           // see R20 R23
            type1_claim    <= type1_valid && (to_secondary || below_window);
        end
    end

endmodule

// [shared/cfg_header_defines.vh]
/*
 * Offsets, field positions, fixed values and timing counts of the bridge
 * configuration header block.
 * Assumes it is included by bare name from the design file.
 */
`ifndef CFG_HEADER_DEFINES_VH
`define CFG_HEADER_DEFINES_VH

// Register byte offsets in configuration space.
`define OFS_PCI_ERROR_STATUS      8'h06
`define OFS_REVISION_LEVEL        8'h08
`define OFS_CLASS_PROG_INTERFACE  8'h09
`define OFS_CLASS_BASE_SUBCLASS   8'h0a
`define OFS_PRIMARY_LATENCY_TIMER 8'h0d
`define OFS_HEADER_LAYOUT_TYPE    8'h0e
`define OFS_SOCKET_REGS_BASE      8'h10
`define OFS_CARD_SIDE_STATUS      8'h16
`define OFS_PRIMARY_BUS_NUMBER    8'h18
`define OFS_SECONDARY_BUS_NUMBER  8'h19
`define OFS_SUBORDINATE_BUS_NUMBER 8'h1a

// Status register bit positions.
`define STS_PARITY_ERR     15
`define STS_SYSTEM_ERR     14
`define STS_MASTER_ABORT   13
`define STS_TARGET_ABORT_R 12
`define STS_TARGET_ABORT_S 11
`define STS_DATA_PARITY    8

// Fixed read values and reset values.
`define STS_DEVSEL_MEDIUM  2'h1
`define STS_RESET          16'h0000
`define CLASS_PROG_VALUE   8'h00
`define CLASS_BASE_VALUE   8'h06
`define CLASS_SUB_VALUE    8'h07
`define HEADER_TYPE_VALUE  8'h82
`define BUS_NUMBER_RESET   8'h00
`define LATENCY_RESET      8'h00
`define SOCKET_BASE_RESET  20'h00000

// Latency timer: one setting step is this many clocks, largest legal setting.
`define LAT_STEP_CLOCKS    7'h08
`define LAT_MAX_SETTING    8'h08

`endif

// [tb/cfg_header_chk.sv]
/* Port checker for the configuration header block.
   Assumes one clock domain and is bound to every cfg_header instance. */
`timescale 1ns/1ps
module cfg_header_chk (
    input wire        core_clk,            // Clock.
    input wire        rst_b,               // Reset, active low.
    input wire        cfg_sel,             // Access request.
    input wire        cfg_wr,              // Write when high.
    input wire [7:0]  cfg_addr,            // Byte address.
    input wire [3:0]  cfg_byte_en,         // Write lanes.
    input wire [31:0] cfg_wdata,           // Write data.
    input wire [31:0] cfg_rdata,           // Read data.
    input wire        cfg_rvalid,          // Read answer.
    input wire        master_active,       // Master owns the bus.
    input wire        grant_b,             // Grant pin, active low.
    input wire        master_end_transfer, // End request.
    input wire        type1_valid,         // Type 1 cycle seen.
    input wire [7:0]  type1_bus,           // Its bus number.
    input wire        type1_claim,         // Claim.
    input wire        type1_to_type0,      // Convert to Type 0.
    input wire        type1_forward        // Forward as Type 1.
);
    reg  [7:0] sec_reg;
    reg  [7:0] sub_reg;
    wire       rd  = cfg_sel && !cfg_wr;
    wire       sts_rd = rd && (cfg_addr[7:2] == 6'h01 || cfg_addr[7:2] == 6'h05);
    wire       hit = type1_bus > sec_reg && type1_bus <= sub_reg;
    ////////////////////
    // Shadow the bus numbers, so range checks need no probes into the design.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_reg <= 8'h00;
            sub_reg <= 8'h00;
        end else if (cfg_sel && cfg_wr && cfg_addr[7:2] == 6'h06) begin
            if (cfg_byte_en[1]) sec_reg <= cfg_wdata[15:8];
            if (cfg_byte_en[2]) sub_reg <= cfg_wdata[23:16];
        end
    end
    ////////////////////
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    a_read_answer: assert property (rd |=> cfg_rvalid)
        else $error("read not answered");
    a_no_stray_valid: assert property (!rd |=> !cfg_rvalid)
        else $error("read answer without read");
    a_status_fixed: assert property (sts_rd |=> cfg_rdata[26:25] == 2'h1
        && cfg_rdata[23:16] == 8'h00) else $error("status fixed bits wrong");
    a_class_fixed: assert property (rd && cfg_addr[7:2] == 6'h02
        |=> cfg_rdata[31:8] == 24'h060700) else $error("class code wrong");
    a_header_fixed: assert property (rd && cfg_addr[7:2] == 6'h03
        |=> cfg_rdata[23:16] == 8'h82) else $error("header type wrong");
    a_base_low_zero: assert property (rd && cfg_addr[7:2] == 6'h04
        |=> cfg_rdata[11:0] == 12'h000) else $error("base low bits not zero");
    a_type0_match: assert property (type1_valid && type1_bus == sec_reg
        |=> type1_claim && type1_to_type0 && !type1_forward) else $error("no Type 0 claim");
    a_forward_range: assert property (type1_valid && hit
        |=> type1_claim && type1_forward && !type1_to_type0) else $error("no forward");
    a_claim_cause: assert property (!(type1_valid && (hit || type1_bus == sec_reg))
        |=> !type1_claim) else $error("claim without match");
    a_end_cause: assert property ($rose(master_end_transfer)
        |-> $past(grant_b, 3) && $past(master_active)) else $error("end while granted");
    c_read: cover property (rd ##1 cfg_rvalid);
    c_forward: cover property (type1_forward);
    c_end: cover property ($rose(master_end_transfer));
endmodule

bind cfg_header cfg_header_chk u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .master_active(master_active),
    .grant_b(grant_b), .master_end_transfer(master_end_transfer),
    .type1_valid(type1_valid), .type1_bus(type1_bus), .type1_claim(type1_claim),
    .type1_to_type0(type1_to_type0), .type1_forward(type1_forward));

// [tb/cfg_host.sv]
/* Host bridge model issuing configuration reads and writes.
   Assumes accesses are taken on the rising edge of core_clk. */
`timescale 1ns/1ps
module cfg_host (
    input  wire        core_clk,    // Clock.
    output reg         cfg_sel,     // Access request.
    output reg         cfg_wr,      // Write when high.
    output reg  [7:0]  cfg_addr,    // Byte address.
    output reg  [3:0]  cfg_byte_en, // Write lanes.
    output reg  [31:0] cfg_wdata,   // Write data.
    input  wire [31:0] cfg_rdata,   // Read data.
    input  wire        cfg_rvalid   // Read answer.
);
    integer gap = 0; // Idle cycles before each access beyond the one always taken, to act slowly.
    initial begin
        cfg_sel = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_byte_en = 4'h0;
        cfg_wdata = 32'h00000000;
    end
    // Released address and data lines show the inverse, so stale values are never mistaken for live ones.
    task wr(input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            repeat (gap + 1) @(posedge core_clk);
            cfg_sel <= 1'b1;
            cfg_wr <= 1'b1;
            cfg_addr <= a;
            cfg_byte_en <= b;
            cfg_wdata <= d;
            @(posedge core_clk);
            cfg_sel <= 1'b0;
            cfg_addr <= ~a;
            cfg_wdata <= ~d;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output v);
        begin
            repeat (gap + 1) @(posedge core_clk);
            cfg_sel <= 1'b1;
            cfg_wr <= 1'b0;
            cfg_addr <= a;
            @(posedge core_clk);
            cfg_sel <= 1'b0;
            cfg_addr <= ~a;
            #1;
            d = cfg_rdata;
            v = cfg_rvalid;
        end
    endtask
endmodule

// [tb/tb.sv]
/* Self-checking bench for the configuration header block.
   Assumes the host model and the bound checker compile alongside. */
`timescale 1ns/1ps
module tb;
    reg         core_clk = 1'b0;
    reg         rst_b    = 1'b0;
    reg  [11:0] ev       = 12'h000; // Parity, system, master abort, ta rx, ta tx, data parity.
    reg         burst    = 1'b0;
    reg         active   = 1'b0;
    reg         grant_b  = 1'b0;
    reg         t1v      = 1'b0;
    reg  [7:0]  t1bus    = 8'h00;
    wire        sel, wr, rvalid, mend, claim, to0, fwd;
    wire [7:0]  addr;
    wire [3:0]  be;
    wire [31:0] wd, rdata;
    integer     error_cnt = 0;
    integer     samples_checked = 0;
    integer     i, c;
    reg  [31:0] d;
    reg         v;
    always #4 core_clk = ~core_clk;
    cfg_host host (.core_clk(core_clk), .cfg_sel(sel), .cfg_wr(wr), .cfg_addr(addr),
        .cfg_byte_en(be), .cfg_wdata(wd), .cfg_rdata(rdata), .cfg_rvalid(rvalid));
    // The revision value is arbitrary.
    cfg_header #(.REVISION_VALUE(8'h3c)) DUT (.core_clk(core_clk), .rst_b(rst_b),
        .cfg_sel(sel), .cfg_wr(wr), .cfg_addr(addr), .cfg_byte_en(be), .cfg_wdata(wd),
        .cfg_rdata(rdata), .cfg_rvalid(rvalid), .pci_parity_err(ev[11]),
        .pci_system_err(ev[10]), .pci_master_abort(ev[9]), .pci_target_abort_rx(ev[8]),
        .pci_target_abort_tx(ev[7]), .pci_data_parity(ev[6]), .card_parity_err(ev[5]),
        .card_system_err(ev[4]), .card_master_abort(ev[3]), .card_target_abort_rx(ev[2]),
        .card_target_abort_tx(ev[1]), .card_data_parity(ev[0]), .master_burst_start(burst),
        .master_active(active), .grant_b(grant_b), .master_end_transfer(mend),
        .type1_valid(t1v), .type1_bus(t1bus), .type1_claim(claim), .type1_to_type0(to0),
        .type1_forward(fwd));
    ////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task rchk(input [7:0] a, input [31:0] m, input [31:0] e);
        begin
            host.rd(a, d, v);
            chk({31'h0, v}, 32'h1);
            chk(d & m, e);
        end
    endtask
    // Event pulses land in the same cycle as the write, to exercise set-over-clear.
    task w(input [7:0] a, input [3:0] b, input [31:0] x, input [11:0] e);
        fork
            host.wr(a, b, x);
            begin
                @(posedge core_clk) ev <= e;
                @(posedge core_clk) ev <= 12'h000;
            end
        join
    endtask
    task t1(input [7:0] b, input [2:0] e);
        begin
            @(posedge core_clk);
            t1v <= 1'b1;
            t1bus <= b;
            @(posedge core_clk);
            t1v <= 1'b0;
            t1bus <= ~b;
            #1;
            chk({29'h0, claim, to0, fwd}, {29'h0, e});
        end
    endtask
    // With g set grant is withdrawn at burst start, so only the timer decides the end.
    // With grant kept the transfer must run on whatever the timer says.
    task lat(input [7:0] n, input g);
        begin
            w(8'h0c, 4'h2, {16'h0, n, 8'h00}, 12'h000);
            @(posedge core_clk);
            burst <= 1'b1;
            active <= 1'b1;
            grant_b <= g;
            @(posedge core_clk) burst <= 1'b0;
            c = 0;
            while (c < 80 && mend !== 1'b1) begin
                @(posedge core_clk);
                #1;
                c = c + 1;
            end
            chk((g && n >= 1 && n <= 8) ? (c >= 8 * n - 1 && c <= 8 * n + 4) : (c == 80), 1);
            @(posedge core_clk);
            active <= 1'b0;
            grant_b <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", samples_checked, error_cnt);
            if (error_cnt == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    ////////////////////
    // The whole run takes well under a thousand cycles.
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        host.gap = 2;
        rchk(8'h04, 32'hffff0000, 32'h02000000);
        rchk(8'h08, 32'hffffffff, 32'h0607003c);
        rchk(8'h0c, 32'h00ffff00, 32'h00820000);
        rchk(8'h10, 32'hffffffff, 32'h00000000);
        rchk(8'h14, 32'hffff0000, 32'h02000000);
        rchk(8'h18, 32'h00ffffff, 32'h00000000);
        host.gap = 0;
        $display("test reset values finished");
        for (i = 1; i < 7; i = i + 1) w({i[5:0], 2'b00}, 4'hf, 32'hffffffff, 12'h000);
        w(8'h40, 4'hf, 32'hffffffff, 12'h000);
        rchk(8'h08, 32'hffffffff, 32'h0607003c);
        rchk(8'h0c, 32'h00ffff00, 32'h0082ff00);
        rchk(8'h10, 32'hffffffff, 32'hfffff000);
        rchk(8'h18, 32'h00ffffff, 32'h00ffffff);
        rchk(8'h14, 32'hffff0000, 32'h02000000);
        rchk(8'h40, 32'hffffffff, 32'h00000000);
        $display("test write all ones finished");
        w(8'h04, 4'h0, 32'h0, 12'hfc0);
        rchk(8'h04, 32'hffff0000, 32'hfb000000);
        w(8'h04, 4'h0, 32'h0, 12'h03f);
        rchk(8'h14, 32'hffff0000, 32'hfb000000);
        w(8'h04, 4'hc, 32'h00000000, 12'h000);
        w(8'h04, 4'h4, 32'hffffffff, 12'h000);
        rchk(8'h04, 32'hffff0000, 32'hfb000000);
        w(8'h04, 4'h8, 32'hc0000000, 12'h400);
        rchk(8'h04, 32'hffff0000, 32'h7b000000);
        w(8'h14, 4'hc, 32'hffff0000, 12'h000);
        rchk(8'h14, 32'hffff0000, 32'h02000000);
        w(8'h04, 4'hc, 32'hffff0000, 12'h000);
        rchk(8'h04, 32'hffff0000, 32'h02000000);
        $display("test status flags finished");
        lat(8'h00, 1'b1);
        lat(8'h01, 1'b1);
        lat(8'h08, 1'b1);
        lat(8'h09, 1'b1);
        lat(8'h01, 1'b0);
        $display("test latency timer finished");
        w(8'h18, 4'h6, 32'h00050300, 12'h000);
        for (i = 2; i < 7; i = i + 1) begin
            t1(i[7:0], i == 3 ? 3'b110 : (i == 4 || i == 5) ? 3'b101 : 3'b000);
        end
        $display("test type 1 steering finished");
        report_and_stop;
    end
endmodule
